// ===== raea_pkg.sv
// package: register map, field layouts and constants of the reactive/apparent energy block
package raea_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GAIN     = 8'h00;
  localparam logic [7:0] ADDR_ENERGY   = 8'h04;
  localparam logic [7:0] ADDR_RCENERGY = 8'h08;
  localparam logic [7:0] ADDR_DIVIDER  = 8'h0C;
  localparam logic [7:0] ADDR_HALFCYC  = 8'h10;
  localparam logic [7:0] ADDR_LINEVAR  = 8'h14;
  localparam logic [7:0] ADDR_LINEVA   = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;
  localparam logic [7:0] ADDR_MASK     = 8'h20;
  localparam logic [7:0] ADDR_CONTROL  = 8'h24;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int GAIN_W    = 12;
  localparam int DIV_W     = 8;
  localparam int HCYC_W    = 16;
  localparam int ACC_W     = 48;
  localparam int ENERGY_W  = 24;
  localparam int SAMPLE_W  = 24;
  localparam int RMS_W     = 24;
  localparam int STAT_W    = 3;
  localparam int ST_HALF   = 0;
  localparam int ST_OVFL   = 1;
  localparam int ST_CYCLE_END_FLAG = 2;
  localparam int CTL_INTEG = 0;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [GAIN_W-1:0] GAIN_RST    = 12'h000;
  localparam logic [DIV_W-1:0]  DIV_RST     = 8'h00;
  localparam logic [HCYC_W-1:0] HCYC_RST    = 16'hFFFF;
  localparam logic [STAT_W-1:0] MASK_RST    = 3'h0;
  localparam int                GAIN_SHIFT  = 12;
  localparam int                LPF_SHIFT   = 8;
  localparam int                SAMPLE_CLKS = 4;
  localparam logic [1:0]        SAMPLE_LAST = 2'(SAMPLE_CLKS - 1);
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] current;
    logic signed [SAMPLE_W-1:0] currentQuad;
    logic signed [SAMPLE_W-1:0] voltage;
    logic [RMS_W-1:0]           currentRms;
    logic [RMS_W-1:0]           voltageRms;
    logic                       zeroCross;
  } raea_samples_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } raea_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } raea_axi_rsp_t;

  typedef enum logic [1:0] {
    WIN_WAIT  = 2'b00,
    WIN_RUN   = 2'b01,
    WIN_CLOSE = 2'b11
  } raea_win_t;

endpackage : raea_pkg

// ===== raea_energy.sv
// module: reactive and apparent power/energy datapath with AXI4-Lite register slave
// Operation
// R1: reactive product is voltage times current shifted ninety degrees in phase.
// R2: reactive power is low-pass filtered product, dropping double-frequency term.
// R3: shift is minus ninety with integrator on, plus ninety with it off.
// R4: reactive power signed; sign follows phase, same with integrator on or off; code negates it with integrator on.
// R5: line reactive energy accumulates over programmed half cycles, up to 65535.
// R6: half-cycle count is unsigned 16-bit half cycles per line window.
// R7: window end sets cycle-end flag; masked flag drives active-low interrupt.
// R8: apparent power is current rms times voltage rms, phase independent.
// R9: apparent power scaled by one plus signed 12-bit gain over 4096.
// R10: apparent path adds no offset correction of its own.
// R11: 48-bit accumulator continuously adds apparent power; upper 24 bits reported.
// R12: one apparent sample added every four master clock periods.
// R13: accumulator additions are signed.
// R14: accumulator divided by unsigned 8-bit divider; zero acts as one.
// R15: 24-bit read-to-clear energy register zeroes after each read.
// R16: half-full and overflow events flagged; half-full judged on 24 bits.
// R17: line apparent energy always accumulates over half cycles from zero crossings.
// R18: line apparent window identical to line active energy window.
// R19: line apparent energy shares path and LSB weight with total apparent energy.
// R20: cycle-end flag is bit 2 of interrupt status.
// R21: half cycles counted from voltage zero-crossing detection.
// R22: accumulator wraps modulo width; overflow event set at that moment.
// R23: next window starts immediately; line registers update at each window end.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module raea_energy (
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  input  wire raea_pkg::raea_samples_t  samples,
  input  wire raea_pkg::raea_axi_req_t  axiReq,
  output raea_pkg::raea_axi_rsp_t       axiRsp,
  output logic                          irqN,
  output logic                          windowEnd
);
  import raea_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [GAIN_W-1:0]          gain;
    logic [DIV_W-1:0]           divider;
    logic [HCYC_W-1:0]          halfCyc;
    logic [STAT_W-1:0]          mask;
    logic [STAT_W-1:0]          status;
    logic                       integOn;
    logic signed [SAMPLE_W-1:0] varFilt;
    logic [SAMPLE_W-1:0]        vaPower;
    logic [1:0]                 phase;
    logic [ACC_W-1:0]           vaAcc;
    logic [ACC_W-1:0]           vaRcAcc;
    logic [ACC_W-1:0]           lineVaAcc;
    logic signed [ACC_W-1:0]    lineVarAcc;
    logic [ENERGY_W-1:0]        lineVa;
    logic [ENERGY_W-1:0]        lineVar;
    logic [HCYC_W-1:0]          hcCount;
    raea_win_t                  win;
    logic                       zcPrev;
    logic                       winEnd;
    logic                       awHeld;
    logic [7:0]                 awAddr;
    logic                       wHeld;
    logic [31:0]                wData;
    logic                       bValid;
    logic [1:0]                 bResp;
    logic                       rValid;
    logic [31:0]                rData;
    logic [1:0]                 rResp;
  } raea_state_t;

  raea_state_t state_q;
  raea_state_t state_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // divide a raw accumulator and keep its upper 24 bits; zero divides by one
  function automatic logic [ENERGY_W-1:0] scaleEnergy(input logic [ACC_W-1:0] acc,
                                                      input logic [DIV_W-1:0] dv);
    logic [ACC_W-1:0] quot;
    quot = (dv == '0) ? acc : acc / ACC_W'(dv); // R14
    return quot[ACC_W-1 -: ENERGY_W]; // R11 R19
  endfunction : scaleEnergy

  function automatic logic [31:0] zext24(input logic [ENERGY_W-1:0] v);
    return {{(32-ENERGY_W){1'b0}}, v};
  endfunction : zext24

  // ----------------------------------------------------------------
  // combinational datapath
  // ----------------------------------------------------------------
  logic signed [SAMPLE_W-1:0]     quadCur;
  logic signed [2*SAMPLE_W-1:0]   varProd;
  logic signed [SAMPLE_W-1:0]     varInst;
  logic [2*RMS_W-1:0]             vaRaw;
  logic signed [2*SAMPLE_W+1:0]   vaGained;
  logic signed [2*RMS_W+GAIN_W+1:0] vaScaled;
  logic [ACC_W:0]                 vaSum;
  logic                           sampleTick;
  logic                           zcEdge;
  logic                           awFire;
  logic                           wFire;
  logic                           arFire;
  logic [STAT_W-1:0]              events;
  logic [ENERGY_W-1:0]            totalNow;
  logic [ENERGY_W-1:0]            totalNext;

  always_comb begin
    state_d = state_q;

    // reactive path: quadrature current direction depends on integrator
    quadCur = state_q.integOn ? -samples.currentQuad : samples.currentQuad; // R3 R4
    varProd = samples.voltage * quadCur; // R1
    varInst = varProd[2*SAMPLE_W-2 -: SAMPLE_W];
    // single-pole low-pass keeps only the dc term; slow settling traded for no multiplier
    state_d.varFilt = state_q.varFilt + SAMPLE_W'((varInst - state_q.varFilt) >>> LPF_SHIFT); // R2

    // apparent path: no offset term is ever added here
    vaRaw = samples.currentRms * samples.voltageRms; // R8 R10
    // product kept full width; a 50-bit context wraps at large gain codes
    vaScaled = ($signed({2'b00, vaRaw}) * $signed(state_q.gain)) >>> GAIN_SHIFT;
    vaGained = $signed({2'b00, vaRaw}) + $signed(vaScaled[2*RMS_W+1:0]); // R9
    state_d.vaPower = vaGained[2*RMS_W-1 -: SAMPLE_W];

    // four-clock sample enable
    sampleTick = (state_q.phase == SAMPLE_LAST); // R12
    state_d.phase = state_q.phase + 2'h1;

    events = '0;
    vaSum = '0;
    if (sampleTick) begin
      // signed addition, carry out of 48 bits means wrap
      vaSum = {1'b0, state_q.vaAcc} + {{(ACC_W-SAMPLE_W+1){state_q.vaPower[SAMPLE_W-1]}},
              state_q.vaPower}; // R13
      state_d.vaAcc = vaSum[ACC_W-1:0]; // R11 R22
      state_d.vaRcAcc = state_q.vaRcAcc + {{(ACC_W-SAMPLE_W){state_q.vaPower[SAMPLE_W-1]}},
                        state_q.vaPower}; // R15
      state_d.lineVaAcc = state_q.lineVaAcc + {{(ACC_W-SAMPLE_W){state_q.vaPower[SAMPLE_W-1]}},
                          state_q.vaPower}; // R17 R19
      state_d.lineVarAcc = state_q.lineVarAcc + {{(ACC_W-SAMPLE_W){state_q.varFilt[SAMPLE_W-1]}},
                           state_q.varFilt}; // R5
      events[ST_OVFL] = vaSum[ACC_W] & ~state_q.vaPower[SAMPLE_W-1]; // R16 R22
    end
    totalNow  = scaleEnergy(state_q.vaAcc, state_q.divider);
    totalNext = scaleEnergy(state_d.vaAcc, state_q.divider);
    events[ST_HALF] = ~totalNow[ENERGY_W-1] & totalNext[ENERGY_W-1]; // R16

    // line window on voltage zero crossings
    zcEdge = samples.zeroCross & ~state_q.zcPrev; // R21
    state_d.zcPrev = samples.zeroCross;
    state_d.winEnd = 1'b0;
    unique case (state_q.win)
      WIN_WAIT: begin
        if (zcEdge) begin
          state_d.win = WIN_RUN;
          state_d.hcCount = '0;
          state_d.lineVaAcc = '0;
          state_d.lineVarAcc = '0;
        end
      end
      WIN_RUN: begin
        if (zcEdge) begin
          state_d.hcCount = state_q.hcCount + 16'h0001;
          if (state_q.hcCount + 16'h0001 >= state_q.halfCyc) begin // R5 R6 R17 R18
            state_d.win = WIN_CLOSE;
          end
        end
      end
      WIN_CLOSE: begin
        // latch results and restart at once on the same crossing grid
        state_d.lineVa = scaleEnergy(state_q.lineVaAcc, state_q.divider); // R19 R23
        state_d.lineVar = state_q.lineVarAcc[ACC_W-1 -: ENERGY_W]; // R5 R23
        state_d.lineVaAcc = '0;
        state_d.lineVarAcc = '0;
        state_d.hcCount = '0;
        state_d.winEnd = 1'b1;
        state_d.win = WIN_RUN; // R23
        events[ST_CYCLE_END_FLAG] = 1'b1; // R7 R20
      end
      default: state_d.win = WIN_WAIT;
    endcase
    // a zero count closes the window at every crossing; treated as one half cycle
    if (state_q.halfCyc == '0 && state_q.win == WIN_RUN && zcEdge) begin
      state_d.win = WIN_CLOSE;
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    awFire = axiReq.awvalid & ~state_q.awHeld & ~state_q.bValid;
    wFire  = axiReq.wvalid & ~state_q.wHeld & ~state_q.bValid;
    arFire = axiReq.arvalid & ~state_q.rValid;
    if (awFire) begin
      state_d.awHeld = 1'b1;
      state_d.awAddr = axiReq.awaddr;
    end
    if (wFire) begin
      state_d.wHeld = 1'b1;
      state_d.wData = axiReq.wdata;
    end
    if (state_q.awHeld && state_q.wHeld) begin
      state_d.awHeld = 1'b0;
      state_d.wHeld = 1'b0;
      state_d.bValid = 1'b1;
      state_d.bResp = RESP_OKAY;
      unique case (state_q.awAddr)
        ADDR_GAIN:    state_d.gain = state_q.wData[GAIN_W-1:0];
        ADDR_DIVIDER: state_d.divider = state_q.wData[DIV_W-1:0];
        ADDR_HALFCYC: state_d.halfCyc = state_q.wData[HCYC_W-1:0]; // R6
        ADDR_MASK:    state_d.mask = state_q.wData[STAT_W-1:0];
        ADDR_CONTROL: state_d.integOn = state_q.wData[CTL_INTEG]; // R3
        // write one to clear; a same-cycle event still wins below
        ADDR_STATUS:  state_d.status = state_q.status & ~state_q.wData[STAT_W-1:0];
        ADDR_ENERGY, ADDR_RCENERGY, ADDR_LINEVAR, ADDR_LINEVA: ;
        default:      state_d.bResp = RESP_SLVERR;
      endcase
    end
    if (state_q.bValid && axiReq.bready) begin
      state_d.bValid = 1'b0;
    end
    if (arFire) begin
      state_d.rValid = 1'b1;
      state_d.rResp = RESP_OKAY;
      unique case (axiReq.araddr)
        ADDR_GAIN:     state_d.rData = {20'h00000, state_q.gain};
        ADDR_ENERGY:   state_d.rData = zext24(totalNow); // R11
        ADDR_RCENERGY: begin
          state_d.rData = zext24(scaleEnergy(state_q.vaRcAcc, state_q.divider)); // R15
          state_d.vaRcAcc = '0; // R15
        end
        ADDR_DIVIDER:  state_d.rData = {24'h000000, state_q.divider};
        ADDR_HALFCYC:  state_d.rData = {16'h0000, state_q.halfCyc};
        ADDR_LINEVAR:  state_d.rData = zext24(state_q.lineVar);
        ADDR_LINEVA:   state_d.rData = zext24(state_q.lineVa);
        ADDR_STATUS:   state_d.rData = {29'h00000000, state_q.status};
        ADDR_MASK:     state_d.rData = {29'h00000000, state_q.mask};
        ADDR_CONTROL:  state_d.rData = {31'h00000000, state_q.integOn};
        default: begin
          state_d.rData = 32'h00000000;
          state_d.rResp = RESP_SLVERR;
        end
      endcase
    end
    if (state_q.rValid && axiReq.rready) begin
      state_d.rValid = 1'b0;
    end

    // set wins over clear
    state_d.status = state_d.status | events; // R7 R16
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= '0;
      state_q.gain <= GAIN_RST;
      state_q.divider <= DIV_RST;
      state_q.halfCyc <= HCYC_RST;
      state_q.mask <= MASK_RST;
      state_q.win <= WIN_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign irqN = ~|(state_q.status & state_q.mask); // R7 R16
  assign windowEnd = state_q.winEnd;
  assign axiRsp.awready = ~state_q.awHeld & ~state_q.bValid;
  assign axiRsp.wready  = ~state_q.wHeld & ~state_q.bValid;
  assign axiRsp.bvalid  = state_q.bValid;
  assign axiRsp.bresp   = state_q.bResp;
  assign axiRsp.arready = ~state_q.rValid;
  assign axiRsp.rvalid  = state_q.rValid;
  assign axiRsp.rdata   = state_q.rData;
  assign axiRsp.rresp   = state_q.rResp;

endmodule : raea_energy

// ===== raea_energy_asserts.sv
// port checker for the reactive/apparent energy block
`timescale 1ns/1ns
module raea_energy_asserts (
  input wire logic                    sys_clk,
  input wire logic                    srst,
  input wire raea_pkg::raea_samples_t samples,
  input wire raea_pkg::raea_axi_req_t axiReq,
  input wire raea_pkg::raea_axi_rsp_t axiRsp,
  input wire logic                    irqN,
  input wire logic                    windowEnd
);
  import raea_pkg::*;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // cycles since the last zero-crossing rise, saturating
  logic [3:0] zcAge_q;
  logic       zcPrev_q;
  always_ff @(posedge sys_clk) begin
    zcPrev_q <= samples.zeroCross;
    if (srst) zcAge_q <= 4'hF;
    else if (samples.zeroCross && !zcPrev_q) zcAge_q <= 4'h0;
    else if (zcAge_q != 4'hF) zcAge_q <= zcAge_q + 4'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_wr_take;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  sequence s_b_up;
    ##[1:2] axiRsp.bvalid;
  endsequence
  property p_wr_answer; s_wr_take |-> s_b_up; endproperty
  property p_b_hold; axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp); endproperty
  property p_r_hold; axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata); endproperty
  property p_rd_answer; axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid; endproperty
  property p_ar_block; axiRsp.rvalid |-> !axiRsp.arready; endproperty
  property p_rd_unmapped;
    axiReq.arvalid && axiRsp.arready && axiReq.araddr > ADDR_CONTROL
      |=> axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == 32'h0;
  endproperty
  property p_hcyc_width;
    axiReq.arvalid && axiRsp.arready && axiReq.araddr == ADDR_HALFCYC |=> axiRsp.rdata[31:16] == 16'h0;
  endproperty
  property p_gain_width;
    axiReq.arvalid && axiRsp.arready && axiReq.araddr == ADDR_GAIN |=> axiRsp.rdata[31:12] == 20'h0;
  endproperty
  property p_we_pulse; windowEnd |=> !windowEnd; endproperty
  property p_we_cause; windowEnd |-> zcAge_q <= 4'h8; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer missing");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
  a_hcyc_width: assert property (p_hcyc_width) else $error("half cycle count too wide");
  a_gain_width: assert property (p_gain_width) else $error("gain too wide");
  a_we_pulse: assert property (p_we_pulse) else $error("window end longer than one cycle");
  a_we_cause: assert property (p_we_cause) else $error("window end without zero crossing");
endmodule : raea_energy_asserts

bind raea_energy raea_energy_asserts raea_energy_asserts_inst (.sys_clk(sys_clk), .srst(srst),
  .samples(samples), .axiReq(axiReq), .axiRsp(axiRsp), .irqN(irqN), .windowEnd(windowEnd));

// ===== raea_energy_tb_top.sv
// self-checking testbench for the reactive/apparent energy block
`timescale 1ns/1ns
module raea_energy_tb_top;
  import raea_pkg::*;
  logic          sys_clk     = 1'b0;
  logic          srst        = 1'b1;
  raea_samples_t samples     = '0;
  raea_samples_t samplesIn;
  logic          zcLine      = 1'b0;
  raea_axi_req_t axiReq      = '0;
  raea_axi_rsp_t axiRsp;
  logic          irqN;
  logic          windowEnd;
  logic          zcOn        = 1'b0;
  int            err_total   = 0;
  int            check_count = 0;
  int            cyc         = 0;
  int            weCount     = 0;
  int            weLast      = 0;
  int            wePrev      = 0;
  int            zcCnt       = 0;
  logic [31:0]   rd;
  logic [31:0]   v0;
  logic [31:0]   v1;
  logic [1:0]    rr;
  always #5 sys_clk = ~sys_clk;
  raea_energy raea_energy_inst (.sys_clk(sys_clk), .srst(srst), .samples(samplesIn), .axiReq(axiReq),
    .axiRsp(axiRsp), .irqN(irqN), .windowEnd(windowEnd));
  // ----------------------------------------------------------------
  // line source and window monitor
  // ----------------------------------------------------------------
  // period 80 is a multiple of the sample tick, so windows hold equal sample counts
  always @(posedge sys_clk) begin
    zcCnt <= (zcCnt == 79) ? 0 : zcCnt + 1;
    zcLine <= zcOn && (zcCnt < 40);
  end
  // line source owns only the crossing bit; scenarios own the rest
  always_comb begin
    samplesIn = samples;
    samplesIn.zeroCross = zcLine;
  end
  always @(negedge sys_clk) begin
    cyc++;
    if (windowEnd === 1'b1) begin
      weCount++;
      wePrev = weLast;
      weLast = cyc;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic do_reset;
    @(posedge sys_clk);
    srst <= 1'b1;
    tick(8);
    srst <= 1'b0;
  endtask : do_reset
  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge sys_clk);
    axiReq.awaddr <= a;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw = axiReq.awvalid && axiRsp.awready;
      w = axiReq.wvalid && axiRsp.wready;
      b = axiRsp.bvalid === 1'b1;
      r = axiRsp.bresp;
      @(posedge sys_clk);
      if (aw) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
    end while (!b);
    axiReq.bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, got;
    @(posedge sys_clk);
    axiReq.araddr <= a;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar = axiReq.arvalid && axiRsp.arready;
      got = axiRsp.rvalid === 1'b1;
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      @(posedge sys_clk);
      if (ar) axiReq.arvalid <= 1'b0;
    end while (!got);
    axiReq.rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(nm, d, exp);
  endtask : rdc
  task automatic wait_we(input int k);
    int t, n;
    t = weCount + k;
    for (n = 0; n < 2000 * k && weCount < t; n++) @(negedge sys_clk);
    // a window that never closes counts against the run
    if (weCount < t) err_total++;
  endtask : wait_we
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc("gain rst", ADDR_GAIN, 32'h0);
    rdc("div rst", ADDR_DIVIDER, 32'h0);
    rdc("hcyc rst", ADDR_HALFCYC, 32'h0000FFFF);
    rdc("stat rst", ADDR_STATUS, 32'h0);
    wr(ADDR_GAIN, 32'hFFFFFFFF);
    rdc("gain wide", ADDR_GAIN, 32'h00000FFF);
    wr(ADDR_DIVIDER, 32'hFFFFFFFF);
    rdc("div wide", ADDR_DIVIDER, 32'h000000FF);
    axi_wr(8'h30, 32'h1, rr);
    check("wr unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
    axi_rd(8'h30, rd, rr);
    check("rd unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
    axi_wr(ADDR_ENERGY, 32'h1, rr);
    check("wr read-only", {30'h0, rr}, {30'h0, RESP_OKAY});
  endtask : t_regs
  // same read-wait-read spacing each time so the counts compare directly
  task automatic t_apparent;
    do_reset();
    axi_rd(ADDR_RCENERGY, rd, rr);
    tick(4000);
    rdc("no offset", ADDR_RCENERGY, 32'h0);
    samples.currentRms <= 24'h400000;
    samples.voltageRms <= 24'h400000;
    axi_rd(ADDR_RCENERGY, rd, rr);
    tick(8000);
    axi_rd(ADDR_RCENERGY, v0, rr);
    rdc("cleared", ADDR_RCENERGY, 32'h0);
    check("power seen", 32'(v0 > 32'h40), 32'h1);
    // 8003 clocks between clears, one sample per four, 2^20 per sample, top 24 of 48 bits
    check("tick rate", v0, 32'd125);
    wr(ADDR_GAIN, 32'h7FF);
    axi_rd(ADDR_RCENERGY, rd, rr);
    tick(8000);
    axi_rd(ADDR_RCENERGY, v1, rr);
    check("gain plus", 32'(2 * v1 >= 3 * v0 - 6 && 2 * v1 <= 3 * v0 + 6), 32'h1);
    wr(ADDR_GAIN, 32'h800);
    axi_rd(ADDR_RCENERGY, rd, rr);
    tick(8000);
    axi_rd(ADDR_RCENERGY, v1, rr);
    check("gain minus", 32'(2 * v1 >= v0 - 3 && 2 * v1 <= v0 + 3), 32'h1);
  endtask : t_apparent
  task automatic t_divider;
    logic [31:0] e [3];
    for (int i = 0; i < 3; i++) begin
      do_reset();
      wr(ADDR_DIVIDER, 32'(i));
      tick(8000);
      axi_rd(ADDR_ENERGY, e[i], rr);
    end
    check("div zero", e[1], e[0]);
    check("div two", 32'(e[2] + 1 >= e[0] / 2 && e[2] <= e[0] / 2 + 1), 32'h1);
  endtask : t_divider
  task automatic t_line;
    do_reset();
    samples.voltage <= 24'h400000;
    samples.currentQuad <= 24'h400000;
    wr(ADDR_HALFCYC, 32'h3);
    wr(ADDR_MASK, 32'h4);
    zcOn <= 1'b1;
    wait_we(3);
    check("window len", 32'(weLast - wePrev), 32'd240);
    rdc("cycle end", ADDR_STATUS, 32'h4);
    check("irq low", {31'h0, irqN}, 32'h0);
    wr(ADDR_STATUS, 32'h4);
    tick(2);
    check("irq cleared", {31'h0, irqN}, 32'h1);
    wait_we(8);
    axi_rd(ADDR_LINEVA, v0, rr);
    wait_we(1);
    axi_rd(ADDR_LINEVA, v1, rr);
    check("line va equal", v1, v0);
    check("line va set", 32'(v0 != 0), 32'h1);
    axi_rd(ADDR_LINEVAR, rd, rr);
    check("var set", 32'(rd != 0), 32'h1);
    check("var plus", {31'h0, rd[23]}, 32'h0);
    wr(ADDR_CONTROL, 32'h1);
    wait_we(12);
    axi_rd(ADDR_LINEVAR, rd, rr);
    check("var minus", {31'h0, rd[23]}, 32'h1);
  endtask : t_line
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    tick(8);
    srst <= 1'b0;
    t_regs();
    t_apparent();
    t_divider();
    t_line();
    report_and_stop();
  end
  // roughly twice the expected run length
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
endmodule : raea_energy_tb_top
